// ===== design/csf_pkg.sv
// csf_pkg: constants and types for the cpu status flags register
// assumes: one core clock, instruction results presented by the decoder
package csf_pkg;
	// ------------------------------------------------------------
	// register map and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] CSF_STATUS_ADDR = 8'h03;
	localparam int CSF_BIT_WAKE = 7;
	localparam int CSF_BIT_RSVD = 6;
	localparam int CSF_BIT_PAGE = 5;
	localparam int CSF_BIT_EXP = 4;
	localparam int CSF_BIT_SLEEP = 3;
	localparam int CSF_BIT_ZERO = 2;
	localparam int CSF_BIT_NIB = 1;
	localparam int CSF_BIT_CARRY = 0;
	// power-on values of the upper bits and reset-cause bits
	localparam logic CSF_RST_WAKE = 1'b0;
	localparam logic CSF_RST_PAGE = 1'b0;
	localparam logic CSF_POR_CAUSE = 1'b1;
	// arithmetic flags are undefined at power-on; zero chosen
	localparam logic [2:0] CSF_RST_ARITH = 3'h0;
	// program counter page bit position
	localparam int CSF_PC_PAGE_BIT = 9;
	localparam int CSF_PC_W = 10;
	localparam int CSF_OP_W = 8;

	// ------------------------------------------------------------
	// operation codes from the instruction decoder
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CSF_OP_NONE,
		CSF_OP_MOVE_W_TO_FILE,
		CSF_OP_BIT_CLEAR,
		CSF_OP_BIT_SET,
		CSF_OP_FILE_CLEAR,
		CSF_OP_ADD_W_FILE,
		CSF_OP_SUB_W_FILE,
		CSF_OP_ROTATE_RIGHT,
		CSF_OP_ROTATE_LEFT,
		CSF_OP_LOGIC,
		CSF_OP_WATCHDOG_CLEAR,
		CSF_OP_SLEEP
	} csf_op_t;

	// instruction issued in one cycle
	typedef struct packed {
		logic valid;
		csf_op_t op;
		logic [7:0] addr;
		logic [CSF_OP_W-1:0] w_val;
		logic [CSF_OP_W-1:0] f_val;
		logic [2:0] bit_sel;
	} csf_instr_t;

	// reset cause reported by the reset controller
	typedef enum logic [1:0] {
		CSF_RC_POWER_ON,
		CSF_RC_PIN_WAKE,
		CSF_RC_OTHER
	} csf_cause_t;

	// alu result carried to the flag register
	typedef struct packed {
		logic [CSF_OP_W-1:0] value;
		logic affects_z;
		logic affects_dc;
		logic affects_c;
		logic zero;
		logic nib;
		logic carry;
	} csf_alu_t;
endpackage

// ===== design/csf_alu.sv
// csf_alu: combinational alu computing a result and its flags
// assumes: operands are stable for the whole instruction cycle
`timescale 1ns/10ps
module csf_alu
	import csf_pkg::*;
(
	input wire csf_instr_t instr,
	input wire logic carry_in,
	output csf_alu_t res
);
	// ------------------------------------------------------------
	// arithmetic paths
	// ------------------------------------------------------------
	wire logic [CSF_OP_W:0] add_full;
	wire logic [CSF_OP_W:0] sub_full;
	wire logic [4:0] add_low;
	wire logic [4:0] sub_low;
	wire logic [CSF_OP_W-1:0] bit_mask;

	// extra msb holds the carry or the inverted borrow
	assign add_full = {1'b0, instr.f_val} + {1'b0, instr.w_val};
	assign sub_full = {1'b0, instr.f_val} + {1'b0, ~instr.w_val} + 9'h001;
	assign add_low = {1'b0, instr.f_val[3:0]} + {1'b0, instr.w_val[3:0]};
	assign sub_low = {1'b0, instr.f_val[3:0]} + {1'b0, ~instr.w_val[3:0]} + 5'h01;
	assign bit_mask = 8'h01 << instr.bit_sel;

	// ------------------------------------------------------------
	// result and flag selection
	// ------------------------------------------------------------
	always_comb
	begin
		res = '0;
		case (instr.op)
			CSF_OP_MOVE_W_TO_FILE: res.value = instr.w_val;
			CSF_OP_BIT_CLEAR: res.value = instr.f_val & ~bit_mask;
			CSF_OP_BIT_SET: res.value = instr.f_val | bit_mask;
			CSF_OP_FILE_CLEAR:
			begin
				res.value = 8'h00;
				res.affects_z = 1'b1;
			end
			CSF_OP_ADD_W_FILE:
			begin
				res.value = add_full[CSF_OP_W-1:0];
				res.affects_z = 1'b1;
				res.affects_dc = 1'b1;
				res.affects_c = 1'b1;
				res.nib = add_low[4];
				res.carry = add_full[CSF_OP_W];
			end
			CSF_OP_SUB_W_FILE:
			begin
				res.value = sub_full[CSF_OP_W-1:0];
				res.affects_z = 1'b1;
				res.affects_dc = 1'b1;
				res.affects_c = 1'b1;
				res.nib = sub_low[4];
				res.carry = sub_full[CSF_OP_W];
			end
			CSF_OP_ROTATE_RIGHT:
			begin
				res.value = {carry_in, instr.f_val[CSF_OP_W-1:1]};
				res.affects_c = 1'b1;
				res.carry = instr.f_val[0];
			end
			CSF_OP_ROTATE_LEFT:
			begin
				res.value = {instr.f_val[CSF_OP_W-2:0], carry_in};
				res.affects_c = 1'b1;
				res.carry = instr.f_val[CSF_OP_W-1];
			end
			CSF_OP_LOGIC:
			begin
				res.value = instr.f_val & instr.w_val;
				res.affects_z = 1'b1;
			end
			default: res = '0;
		endcase
		res.zero = (res.value == 8'h00);
	end
endmodule

// ===== design/csf_status.sv
// csf_status: cpu status flags register at file address 03h
// assumes: decoder presents one instruction per clock; reset cause
// and watchdog expiry come from logic on the same clock
//
// Contract
// - flag-affecting instruction writing here: arithmetic flags come from result, not data. Code: only flags the op affects come from the result, others from data.
// - watchdog expiry and sleep entered bits never change by instruction writes.
// - file clear here clears bits 7..5, keeps cause bits, sets zero flag.
// - bit clear, bit set, move w to file leave arithmetic flags alone. Code: only when aimed elsewhere; aimed here, their data lands on the flags.
// - pin wake flag is 1 after pin-change wake reset, 0 otherwise.
// - page select bit picks page 1 when set, page 0 when clear.
// - expiry flag set at power-up, watchdog clear, sleep; cleared on time-out.
// - sleep flag set at power-up and watchdog clear; cleared by sleep.
// - zero flag is 1 on zero result, 0 on nonzero result.
// - add: nibble carry is carry out of the fourth low bit.
// - subtract: nibble carry is inverted borrow from the fourth low bit.
// - carry out bit: add carry, or subtract inverted borrow.
// - rotate right loads carry from lsb, rotate left from msb.
// - power-on: upper bits 0, cause bits 1, arithmetic flags undefined.
// - jump uses page select bit as program counter bit nine.
// - every reset clears page select bit to page 0.
`timescale 1ns/10ps
module csf_status
	import csf_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire csf_cause_t rst_cause,
	input wire csf_instr_t instr,
	input wire logic wdt_timeout,
	input wire logic [8:0] jump_target,
	output logic [7:0] status_rd,
	output csf_alu_t alu_res,
	output logic [CSF_PC_W-1:0] jump_pc,
	output logic page_select_bit
);
	// ------------------------------------------------------------
	// flag state
	// ------------------------------------------------------------
	logic pin_wake_flag_reg;
	logic pin_wake_flag_next;
	logic page_select_reg;
	logic page_select_next;
	logic watchdog_expiry_flag_reg;
	logic watchdog_expiry_flag_next;
	logic sleep_entered_flag_reg;
	logic sleep_entered_flag_next;
	logic [2:0] arith_reg;
	logic [2:0] arith_next;
	csf_alu_t alu_w;

	// ------------------------------------------------------------
	// alu
	// ------------------------------------------------------------
	csf_alu u_alu (
		.instr(instr),
		.carry_in(arith_reg[CSF_BIT_CARRY]),
		.res(alu_w)
	);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire logic hit;
	wire logic do_wdt_clr;
	wire logic do_sleep;
	wire logic wr_z;
	wire logic wr_dc;
	wire logic wr_c;
	wire logic [7:0] wv;

	assign hit = instr.valid && (instr.addr == CSF_STATUS_ADDR);
	assign do_wdt_clr = instr.valid && (instr.op == CSF_OP_WATCHDOG_CLEAR);
	assign do_sleep = instr.valid && (instr.op == CSF_OP_SLEEP);
	// a data write lands on a flag only when the op leaves that flag alone
	assign wr_z = hit && !alu_w.affects_z;
	assign wr_dc = hit && !alu_w.affects_dc;
	assign wr_c = hit && !alu_w.affects_c;
	assign wv = alu_w.value;

	// ------------------------------------------------------------
	// next values
	// ------------------------------------------------------------
	always_comb
	begin
		pin_wake_flag_next = pin_wake_flag_reg;
		page_select_next = page_select_reg;
		arith_next = arith_reg;
		// file clear writes zero here, so upper bits clear and z sets
		if (hit)
		begin
			pin_wake_flag_next = wv[CSF_BIT_WAKE];
			page_select_next = wv[CSF_BIT_PAGE];
		end
		// flags from the operation when it affects them
		if (instr.valid && alu_w.affects_z)
			arith_next[CSF_BIT_ZERO] = alu_w.zero;
		else if (wr_z)
			arith_next[CSF_BIT_ZERO] = wv[CSF_BIT_ZERO];
		if (instr.valid && alu_w.affects_dc)
			arith_next[CSF_BIT_NIB] = alu_w.nib;
		else if (wr_dc)
			arith_next[CSF_BIT_NIB] = wv[CSF_BIT_NIB];
		if (instr.valid && alu_w.affects_c)
			arith_next[CSF_BIT_CARRY] = alu_w.carry;
		else if (wr_c)
			arith_next[CSF_BIT_CARRY] = wv[CSF_BIT_CARRY];
	end

	// cause bits follow events only; instruction data never reaches them
	always_comb
	begin
		watchdog_expiry_flag_next = watchdog_expiry_flag_reg;
		sleep_entered_flag_next = sleep_entered_flag_reg;
		if (do_wdt_clr || do_sleep)
			watchdog_expiry_flag_next = 1'b1;
		if (do_wdt_clr)
			sleep_entered_flag_next = 1'b1;
		if (do_sleep)
			sleep_entered_flag_next = 1'b0;
		// a time-out in the same cycle as a clear wins: the event is kept
		if (wdt_timeout)
			watchdog_expiry_flag_next = 1'b0;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// cause bits keep their value across non power-on resets
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_wake_flag_reg <= (rst_cause == CSF_RC_PIN_WAKE) ? 1'b1 : CSF_RST_WAKE;
			page_select_reg <= CSF_RST_PAGE;
			if (rst_cause == CSF_RC_POWER_ON)
			begin
				watchdog_expiry_flag_reg <= CSF_POR_CAUSE;
				sleep_entered_flag_reg <= CSF_POR_CAUSE;
				arith_reg <= CSF_RST_ARITH;
			end
		end
		else
		begin
			pin_wake_flag_reg <= pin_wake_flag_next;
			page_select_reg <= page_select_next;
			watchdog_expiry_flag_reg <= watchdog_expiry_flag_next;
			sleep_entered_flag_reg <= sleep_entered_flag_next;
			arith_reg <= arith_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// bit 6 reads zero and holds no state
	always_comb
	begin
		status_rd = 8'h00;
		status_rd[CSF_BIT_WAKE] = pin_wake_flag_reg;
		status_rd[CSF_BIT_RSVD] = 1'b0;
		status_rd[CSF_BIT_PAGE] = page_select_reg;
		status_rd[CSF_BIT_EXP] = watchdog_expiry_flag_reg;
		status_rd[CSF_BIT_SLEEP] = sleep_entered_flag_reg;
		status_rd[2:0] = arith_reg;
	end

	assign page_select_bit = page_select_reg;
	assign jump_pc = {page_select_reg, jump_target};
	assign alu_res = alu_w;
endmodule

// ===== verification/csf_status_properties.sv
// checker for the status flags register ports
// assumes: bound onto csf_status, one clock, sync reset
`timescale 1ns/10ps
module csf_status_properties
	import csf_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire csf_cause_t rst_cause,
	input wire csf_instr_t instr,
	input wire logic wdt_timeout,
	input wire logic [8:0] jump_target,
	input wire logic [7:0] status_rd,
	input wire csf_alu_t alu_res,
	input wire logic [CSF_PC_W-1:0] jump_pc,
	input wire logic page_select_bit
);
	// --------
	// properties
	// --------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// instruction taken with no time-out racing it
	sequence s_op(csf_op_t o);
		instr.valid && instr.op == o && !wdt_timeout;
	endsequence
	a_reserved_zero: assert property (status_rd[6] == 1'b0)
		else $error("reserved bit reads one");
	a_jump_page: assert property (jump_pc == {page_select_bit, jump_target} && page_select_bit == status_rd[5])
		else $error("jump page bit wrong");
	// reset assertions must see the reset itself, so no disable
	a_reset_wake_page: assert property (disable iff (1'b0) rst |=>
		status_rd[7] == $past(rst_cause == CSF_RC_PIN_WAKE) && !status_rd[5])
		else $error("wake or page bit wrong after reset");
	a_por_values: assert property (disable iff (1'b0) rst && rst_cause == CSF_RC_POWER_ON |=> status_rd == 8'h18)
		else $error("power-on value wrong");
	a_timeout_clear: assert property (wdt_timeout |=> !status_rd[4])
		else $error("time-out did not clear expiry");
	a_wdclear_sets: assert property (s_op(CSF_OP_WATCHDOG_CLEAR) |=> status_rd[4:3] == 2'b11)
		else $error("watchdog clear wrong");
	a_sleep_flags: assert property (s_op(CSF_OP_SLEEP) |=> status_rd[4:3] == 2'b10)
		else $error("sleep flags wrong");
	a_zero_from_alu: assert property (instr.valid && alu_res.affects_z |=> status_rd[2] == $past(alu_res.zero))
		else $error("zero flag wrong");
	a_carry_from_alu: assert property (instr.valid && alu_res.affects_c |=> status_rd[0] == $past(alu_res.carry))
		else $error("carry flag wrong");
	a_cause_kept: assert property (instr.valid && !wdt_timeout
		&& !(instr.op inside {CSF_OP_WATCHDOG_CLEAR, CSF_OP_SLEEP}) |=> $stable(status_rd[4:3]))
		else $error("cause bits changed");
	// a plain write aimed at this register lands its data on the flags, so only other targets count
	a_plain_write: assert property (instr.valid && instr.addr != CSF_STATUS_ADDR
		&& instr.op inside {CSF_OP_MOVE_W_TO_FILE, CSF_OP_BIT_CLEAR, CSF_OP_BIT_SET} |=> $stable(status_rd[2:0]))
		else $error("plain write changed flags");
	a_nib_from_alu: assert property (instr.valid && alu_res.affects_dc |=> status_rd[1] == $past(alu_res.nib))
		else $error("nibble carry wrong");
endmodule

bind csf_status csf_status_properties u_props (.clk(clk), .rst(rst), .rst_cause(rst_cause), .instr(instr),
	.wdt_timeout(wdt_timeout), .jump_target(jump_target), .status_rd(status_rd), .alu_res(alu_res),
	.jump_pc(jump_pc), .page_select_bit(page_select_bit));

// ===== verification/tb_top.sv
// self-checking bench for the status flags register
// assumes: csf_pkg compiled first, checker bound separately
`timescale 1ns/10ps
module tb_top
	import csf_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	csf_cause_t rst_cause = CSF_RC_POWER_ON;
	csf_instr_t instr = '0;
	logic wdt_timeout = 1'b0;
	logic [8:0] jump_target = 9'h0a5;
	logic [7:0] status_rd;
	csf_alu_t alu_res;
	logic [CSF_PC_W-1:0] jump_pc;
	logic page_select_bit;
	int failures = 0;
	int checked = 0;
	always #5 clk = ~clk;
	csf_status DUT (.clk(clk), .rst(rst), .rst_cause(rst_cause), .instr(instr), .wdt_timeout(wdt_timeout),
		.jump_target(jump_target), .status_rd(status_rd), .alu_res(alu_res), .jump_pc(jump_pc),
		.page_select_bit(page_select_bit));
	// --------
	// helpers
	// --------
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one instruction, result settled one cycle later
	task automatic issue(input csf_op_t op, input logic [7:0] a, w, f, input logic [2:0] b, input logic t);
		@(posedge clk);
		instr <= '{1'b1, op, a, w, f, b};
		wdt_timeout <= t;
		@(posedge clk);
		instr.valid <= 1'b0;
		wdt_timeout <= 1'b0;
		#1;
	endtask
	task automatic do_reset(input csf_cause_t c, input int n, input logic [7:0] exp);
		@(posedge clk);
		rst <= 1'b1;
		rst_cause <= c;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(status_rd, exp);
		$display("reset test done");
	endtask
	// flag ops away from the register, expected {zero, nibble, carry}
	task automatic op_f(input csf_op_t op, input logic [7:0] w, f, input logic [2:0] e);
		issue(op, 8'h10, w, f, 3'h0, 1'b0);
		chk(status_rd[2:0], e);
	endtask
	// --------
	// scenarios
	// --------
	task automatic t_arith;
		op_f(CSF_OP_ADD_W_FILE, 8'h0f, 8'h01, 3'b010);
		op_f(CSF_OP_ADD_W_FILE, 8'hff, 8'h01, 3'b111);
		op_f(CSF_OP_ADD_W_FILE, 8'h70, 8'h80, 3'b000);
		op_f(CSF_OP_SUB_W_FILE, 8'h01, 8'h10, 3'b001);
		op_f(CSF_OP_SUB_W_FILE, 8'h01, 8'h00, 3'b000);
		op_f(CSF_OP_SUB_W_FILE, 8'h05, 8'h05, 3'b111);
		op_f(CSF_OP_ROTATE_RIGHT, 8'h00, 8'h02, 3'b110);
		op_f(CSF_OP_ROTATE_LEFT, 8'h00, 8'h80, 3'b111);
		op_f(CSF_OP_LOGIC, 8'hff, 8'h01, 3'b011);
		op_f(CSF_OP_ROTATE_LEFT, 8'h00, 8'h7f, 3'b010);
		op_f(CSF_OP_LOGIC, 8'hf0, 8'h0f, 3'b110);
		$display("arith test done");
	endtask
	// plain ops elsewhere keep every flag; alu value read while the op still stands
	task automatic t_plain;
		issue(CSF_OP_MOVE_W_TO_FILE, 8'h10, 8'h5a, 8'h00, 3'h0, 1'b0);
		chk(status_rd, 8'h1e);
		chk(alu_res.value, 8'h5a);
		issue(CSF_OP_BIT_SET, 8'h10, 8'h00, 8'h00, 3'h3, 1'b0);
		chk(status_rd, 8'h1e);
		chk(alu_res.value, 8'h08);
		issue(CSF_OP_BIT_CLEAR, 8'h10, 8'h00, 8'hff, 3'h1, 1'b0);
		chk(status_rd, 8'h1e);
		chk(alu_res.value, 8'hfd);
		@(posedge clk);
		jump_target <= 9'h15a;
		#1;
		chk(jump_pc, 10'h15a);
		@(posedge clk);
		jump_target <= 9'h0a5;
		$display("plain op test done");
	endtask
	task automatic t_regwrite;
		issue(CSF_OP_MOVE_W_TO_FILE, CSF_STATUS_ADDR, 8'hff, 8'h00, 3'h0, 1'b0);
		chk(status_rd, 8'hbf);
		chk(jump_pc, 10'h2a5);
		issue(CSF_OP_BIT_CLEAR, CSF_STATUS_ADDR, 8'h00, 8'hbe, 3'h7, 1'b0);
		chk(status_rd, 8'h3e);
		issue(CSF_OP_ADD_W_FILE, CSF_STATUS_ADDR, 8'h01, 8'hfe, 3'h0, 1'b0);
		chk(status_rd, 8'hb8);
		issue(CSF_OP_FILE_CLEAR, CSF_STATUS_ADDR, 8'h00, 8'hb8, 3'h0, 1'b0);
		chk(status_rd, 8'h1c);
		chk(jump_pc, 10'h0a5);
		issue(CSF_OP_BIT_SET, CSF_STATUS_ADDR, 8'h00, 8'h1c, 3'h5, 1'b0);
		chk(status_rd, 8'h3c);
		$display("register write test done");
	endtask
	// time-out wins over a clear in the same cycle
	task automatic t_power;
		issue(CSF_OP_SLEEP, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0);
		chk(status_rd, 8'h34);
		issue(CSF_OP_NONE, 8'h00, 8'h00, 8'h00, 3'h0, 1'b1);
		chk(status_rd, 8'h24);
		issue(CSF_OP_WATCHDOG_CLEAR, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0);
		chk(status_rd, 8'h3c);
		issue(CSF_OP_WATCHDOG_CLEAR, 8'h00, 8'h00, 8'h00, 3'h0, 1'b1);
		chk(status_rd, 8'h2c);
		$display("power test done");
	endtask
	task automatic results;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		do_reset(CSF_RC_POWER_ON, 16, 8'h18);
		t_arith;
		t_plain;
		t_regwrite;
		t_power;
		do_reset(CSF_RC_PIN_WAKE, 2, 8'h8c);
		do_reset(CSF_RC_OTHER, 2, 8'h0c);
		do_reset(CSF_RC_POWER_ON, 2, 8'h18);
		results;
	end
	// hang guard
	initial
	begin
		repeat (2000) @(posedge clk);
		failures++;
		results;
	end
endmodule
